// ==== rtl/iso_receive_dma.sv ====
// Summary of operation
// (R1) Four independent receive contexts, each with its own descriptor list.
// (R2) Only one context may take packets from several channels; others match one.
// (R3) Each context places one packet per buffer or fills buffers as a stream.
// (R4) Header and time stamp bytes are stored or left out per context.
// (R5) Descriptors are sixteen bytes and fetched from sixteen-byte aligned addresses.
// (R6) Command code two means continue-input, three means final-input.
// (R7) Software uses only continue-input in stream fill.
// (R8) Software ends packet-per-buffer blocks with final-input, never in stream fill.
// (R9) Status written back when status flag set; always in stream fill.
// (R10) Software writes zero into the key field.
// (R11) Interrupt control eleven raises the receive interrupt on completion.
// (R12) Branch control eleven follows the next-descriptor pointer; zero does not.
// (R13) Software sets branch control as each placement style demands.
// (R14) Wait control eleven drops packets until the sync value matches.
// (R15) Software uses wait only in the first descriptor of a block.
// (R16) Request count bounds the bytes placed in the buffer.
// (R17) Block count zero ends the list, one to eight continue, others reserved.
// (R18) Written status is the low sixteen bits of the context control register.
// (R19) Residual count is the unused byte count of the buffer.
// (R20) Descriptor quadlets are fetched in order: control, buffer, branch, status.
//
// The implementer's own choices: the address map and the APB slave port.
module iso_receive_dma (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic pkt_valid,
    input wire logic [5:0] pkt_channel,
    input wire logic [3:0] pkt_sync,
    input wire logic [15:0] pkt_length,
    output logic pkt_ready,
    output logic iso_receive_irq
);
    import iso_rx_pkg::*;

    typedef struct packed {
        ctx_t [NUM_CTX-1:0] ctx;
        state_t state;
        logic [CTX_W-1:0] cur;
        logic [1:0] fidx;
        logic [16:0] remain;
        logic [3:0] pkt_sync;
        logic done_desc;
        logic mem_req;
        logic mem_we;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic pkt_ready;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } top_t;

    top_t st_q;
    top_t st_d;

    desc_if dif();
    ctx_t cur_ctx;
    logic [NUM_CTX-1:0] run_v;
    logic [NUM_CTX-1:0] multi_v;
    logic [NUM_CTX-1:0][5:0] chan_v;
    logic hit;
    logic [CTX_W-1:0] hit_idx;

    assign cur_ctx = st_q.ctx[st_q.cur];

    always_comb begin
        for (int n = 0; n < NUM_CTX; n++) begin
            run_v[n] = st_q.ctx[n].run;
            multi_v[n] = st_q.ctx[n].multi_chan;
            chan_v[n] = st_q.ctx[n].chan;
        end
    end

    desc_decode u_decode (
        .ctrl_word(cur_ctx.ctrl_word),
        .branch_word(cur_ctx.branch_word),
        .dec(dif.producer)
    );

    ctx_match u_match (
        .run(run_v),
        .multi(multi_v),
        .chan(chan_v),
        .pkt_channel(pkt_channel),
        .hit(hit),
        .idx(hit_idx)
    );

    // Status bits in the low half are what gets copied into written descriptors.
    function automatic logic [31:0] ctrl_view(input ctx_t c);
        logic [31:0] v;
        v = CTRL_RESET;
        v[CTRL_STREAM_BIT] = c.stream_fill_mode;
        v[CTRL_HDR_BIT] = c.keep_hdr;
        v[CTRL_MULTI_BIT] = c.multi_chan;
        v[CTRL_RUN_BIT] = c.run;
        v[CTRL_DEAD_BIT] = c.ended;
        v[CTRL_ACTIVE_BIT] = c.run && !c.ended;
        v[CTRL_ERR_BIT] = c.desc_err;
        return v;
    endfunction : ctrl_view

    always_comb begin
        logic acc;
        logic wr;
        logic ctx_hit;
        logic [CTX_W-1:0] ri;
        logic [16:0] take;
        logic [15:0] new_resid;
        logic list_end;
        logic [31:0] cv;
        cv = ctrl_view(cur_ctx);
        acc = psel && penable && !st_q.pready;
        wr = psel && penable && st_q.pready && pwrite && !st_q.pslverr;
        ctx_hit = (paddr[11:8] == CTX_REGION) && (paddr[7:6] == 2'b00);
        ri = paddr[4 +: CTX_W];
        take = '0;
        new_resid = '0;
        list_end = 1'b0;

        st_d = st_q;
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        st_d.pkt_ready = 1'b0;
        st_d.irq = 1'b0;

        // Bus slave: two-cycle access, answer and read data registered.
        if (acc) begin
            st_d.pready = 1'b1;
            st_d.prdata = '0;
            if (paddr == ADDR_INFO) begin
                st_d.prdata = 32'(NUM_CTX); // [R1]
            end else if (ctx_hit && paddr[3:0] == OFF_CTRL) begin
                st_d.prdata = ctrl_view(st_q.ctx[ri]);
            end else if (ctx_hit && paddr[3:0] == OFF_MATCH) begin
                st_d.prdata[MATCH_CHAN_LSB +: 6] = st_q.ctx[ri].chan;
                st_d.prdata[MATCH_SYNC_LSB +: 4] = st_q.ctx[ri].sync;
            end else if (ctx_hit && paddr[3:0] == OFF_PTR) begin
                st_d.prdata = st_q.ctx[ri].ptr;
            end else begin
                st_d.pslverr = 1'b1;
            end
        end

        // Software writes go first so that engine-set flags below win a clash.
        if (wr && ctx_hit) begin
            unique case (paddr[3:0])
                OFF_CTRL: begin
                    if (pwdata[CTRL_RUN_BIT] && !st_q.ctx[ri].run) begin
                        st_d.ctx[ri].ended = 1'b0;
                        st_d.ctx[ri].loaded = 1'b0;
                        st_d.ctx[ri].desc_err = 1'b0;
                    end
                    st_d.ctx[ri].run = pwdata[CTRL_RUN_BIT];
                    st_d.ctx[ri].stream_fill_mode = pwdata[CTRL_STREAM_BIT]; // [R3]
                    st_d.ctx[ri].keep_hdr = pwdata[CTRL_HDR_BIT]; // [R4]
                    st_d.ctx[ri].multi_chan = pwdata[CTRL_MULTI_BIT]; // [R2]
                end
                OFF_MATCH: begin
                    st_d.ctx[ri].chan = pwdata[MATCH_CHAN_LSB +: 6];
                    st_d.ctx[ri].sync = pwdata[MATCH_SYNC_LSB +: 4];
                end
                OFF_PTR: begin
                    // Pointer moves only while stopped; the low nibble is forced clear.
                    if (!st_q.ctx[ri].run) begin
                        st_d.ctx[ri].ptr = {pwdata[31:4], 4'h0}; // [R5]
                    end
                end
                default: begin
                end
            endcase
        end

        unique case (st_q.state)
            S_IDLE: begin
                // Unmatched packets are still accepted so the link never blocks.
                if (pkt_valid && !st_q.pkt_ready) begin
                    st_d.pkt_ready = 1'b1;
                    st_d.cur = hit_idx;
                    st_d.pkt_sync = pkt_sync;
                    st_d.remain = {1'b0, pkt_length};
                    if (st_q.ctx[hit_idx].keep_hdr) begin
                        st_d.remain = {1'b0, pkt_length} + HDR_BYTES; // [R4]
                    end
                    st_d.fidx = 2'b00;
                    if (hit && !st_q.ctx[hit_idx].ended) begin
                        st_d.state = st_q.ctx[hit_idx].loaded ? S_PLACE : S_FETCH;
                    end
                end
            end
            S_FETCH: begin
                st_d.mem_we = 1'b0;
                st_d.mem_addr = cur_ctx.ptr + {28'h0, st_q.fidx, 2'b00}; // [R5] [R20]
                if (st_q.mem_req && mem_ack) begin
                    st_d.mem_req = 1'b0;
                    st_d.fidx = st_q.fidx + 2'b01;
                    unique case (st_q.fidx)
                        2'b00: begin
                            st_d.ctx[st_q.cur].ctrl_word = mem_rdata;
                            st_d.ctx[st_q.cur].residual_byte_count = mem_rdata[15:0]; // [R19]
                        end
                        2'b01: st_d.ctx[st_q.cur].buffer_pointer = mem_rdata;
                        2'b10: st_d.ctx[st_q.cur].branch_word = mem_rdata;
                        2'b11: begin
                            // Old status is read for order only and then discarded.
                            st_d.ctx[st_q.cur].loaded = 1'b1; // [R20]
                            st_d.ctx[st_q.cur].sync_seen = 1'b0;
                            st_d.state = S_PLACE;
                        end
                    endcase
                end else begin
                    st_d.mem_req = 1'b1;
                end
            end
            S_PLACE: begin
                if (!dif.cmd_ok || !dif.key_ok) begin
                    st_d.ctx[st_q.cur].desc_err = 1'b1; // [R6]
                    st_d.ctx[st_q.cur].ended = 1'b1;
                    st_d.state = S_IDLE;
                end else if (dif.wait_en && !cur_ctx.sync_seen
                        && st_q.pkt_sync != cur_ctx.sync) begin
                    st_d.state = S_IDLE; // [R14]
                end else begin
                    st_d.ctx[st_q.cur].sync_seen = 1'b1; // [R14]
                    // Never place more than the buffer still holds.
                    take = (st_q.remain < {1'b0, cur_ctx.residual_byte_count})
                        ? st_q.remain : {1'b0, cur_ctx.residual_byte_count}; // [R16]
                    new_resid = cur_ctx.residual_byte_count - take[15:0]; // [R19]
                    st_d.ctx[st_q.cur].residual_byte_count = new_resid;
                    st_d.remain = st_q.remain - take;
                    st_d.done_desc = cur_ctx.stream_fill_mode ? (new_resid == 16'h0000)
                        : 1'b1; // [R3]
                    // Stream fill reports every packet; the other style only if asked.
                    if (cur_ctx.stream_fill_mode || dif.status_en) begin // [R9]
                        st_d.state = S_WRITE;
                    end else begin
                        st_d.state = S_ADVANCE;
                    end
                end
            end
            S_WRITE: begin
                st_d.mem_we = 1'b1;
                st_d.mem_addr = cur_ctx.ptr + STATUS_OFFSET;
                st_d.mem_wdata = {cv[15:0], cur_ctx.residual_byte_count}; // [R18]
                if (st_q.mem_req && mem_ack) begin
                    st_d.mem_req = 1'b0;
                    st_d.mem_we = 1'b0;
                    st_d.state = S_ADVANCE;
                end else begin
                    st_d.mem_req = 1'b1;
                end
            end
            S_ADVANCE: begin
                st_d.state = S_IDLE;
                if (st_q.done_desc) begin
                    st_d.irq = dif.irq_en; // [R11]
                    st_d.ctx[st_q.cur].loaded = 1'b0;
                    if (dif.is_last || cur_ctx.stream_fill_mode) begin
                        if (!dif.blk_ok) begin
                            st_d.ctx[st_q.cur].desc_err = 1'b1; // [R17]
                        end
                        list_end = !dif.branch_en || dif.blk_count == Z_END
                            || !dif.blk_ok; // [R12] [R17]
                        if (list_end) begin
                            st_d.ctx[st_q.cur].ended = 1'b1;
                        end else begin
                            st_d.ctx[st_q.cur].ptr = dif.next_descriptor_pointer; // [R12]
                        end
                    end else begin
                        // Continue-input inside a block: the next one is contiguous.
                        st_d.ctx[st_q.cur].ptr = cur_ctx.ptr + DESC_BYTES; // [R6] [R5]
                    end
                    // Spill over into the next buffer unless the packet is finished, the list has ended or a packet-per-buffer block has ended.
                    if (st_q.remain != '0 && !list_end
                            && (cur_ctx.stream_fill_mode || !dif.is_last)) begin
                        st_d.fidx = 2'b00;
                        st_d.state = S_FETCH;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign mem_req = st_q.mem_req;
    assign mem_we = st_q.mem_we;
    assign mem_addr = st_q.mem_addr;
    assign mem_wdata = st_q.mem_wdata;
    assign pkt_ready = st_q.pkt_ready;
    assign iso_receive_irq = st_q.irq;
endmodule : iso_receive_dma

// ==== rtl/iso_rx_pkg.sv ====
package iso_rx_pkg;
    localparam int NUM_CTX = 4;
    localparam int CTX_W = 2;

    localparam logic [11:0] ADDR_INFO = 12'h000;
    localparam logic [3:0] CTX_REGION = 4'h1;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_MATCH = 4'h4;
    localparam logic [3:0] OFF_PTR = 4'h8;

    localparam int CTRL_STREAM_BIT = 31;
    localparam int CTRL_HDR_BIT = 30;
    localparam int CTRL_MULTI_BIT = 28;
    localparam int CTRL_RUN_BIT = 15;
    localparam int CTRL_DEAD_BIT = 11;
    localparam int CTRL_ACTIVE_BIT = 10;
    localparam int CTRL_ERR_BIT = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int MATCH_CHAN_LSB = 0;
    localparam int MATCH_SYNC_LSB = 8;

    localparam int CMD_LSB = 28;
    localparam int S_BIT = 27;
    localparam int KEY_LSB = 24;
    localparam int I_LSB = 20;
    localparam int B_LSB = 18;
    localparam int W_LSB = 16;
    localparam logic [3:0] CMD_MORE = 4'h2;
    localparam logic [3:0] CMD_LAST = 4'h3;
    localparam logic [1:0] CTL_ON = 2'b11;
    localparam logic [1:0] CTL_OFF = 2'b00;
    localparam logic [2:0] KEY_ZERO = 3'h0;
    localparam logic [3:0] Z_END = 4'h0;
    localparam logic [3:0] Z_MAX = 4'h8;

    localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_000c;
    localparam logic [16:0] HDR_BYTES = 17'h0_0008;

    typedef enum logic [2:0] {
        S_IDLE,
        S_FETCH,
        S_PLACE,
        S_WRITE,
        S_ADVANCE
    } state_t;

    typedef struct packed {
        logic [31:0] ctrl_word;
        logic [31:0] buffer_pointer;
        logic [31:0] branch_word;
        logic [15:0] residual_byte_count;
        logic [31:0] ptr;
        logic loaded;
        logic ended;
        logic desc_err;
        logic sync_seen;
        logic run;
        logic stream_fill_mode;
        logic keep_hdr;
        logic multi_chan;
        logic [5:0] chan;
        logic [3:0] sync;
    } ctx_t;
endpackage : iso_rx_pkg

// ==== rtl/desc_if.sv ====
interface desc_if;
    logic [3:0] cmd;
    logic status_en;
    logic key_ok;
    logic irq_en;
    logic branch_en;
    logic wait_en;
    logic [15:0] request_byte_count;
    logic [31:0] next_descriptor_pointer;
    logic [3:0] blk_count;
    logic is_last;
    logic cmd_ok;
    logic blk_ok;

    modport producer(output cmd, status_en, key_ok, irq_en, branch_en, wait_en,
        request_byte_count, next_descriptor_pointer, blk_count, is_last, cmd_ok, blk_ok);
    modport consumer(input cmd, status_en, key_ok, irq_en, branch_en, wait_en,
        request_byte_count, next_descriptor_pointer, blk_count, is_last, cmd_ok, blk_ok);
endinterface : desc_if

// ==== rtl/desc_decode.sv ====
module desc_decode
    import iso_rx_pkg::*;
(
    input wire logic [31:0] ctrl_word,
    input wire logic [31:0] branch_word,
    desc_if.producer dec
);
    // Encodings 01 and 10 of the two-bit controls count as off, the safe choice.
    always_comb begin
        dec.cmd = ctrl_word[CMD_LSB +: 4];
        dec.is_last = (dec.cmd == CMD_LAST);
        dec.cmd_ok = (dec.cmd == CMD_MORE) || dec.is_last;
        dec.status_en = ctrl_word[S_BIT];
        dec.key_ok = (ctrl_word[KEY_LSB +: 3] == KEY_ZERO);
        dec.irq_en = (ctrl_word[I_LSB +: 2] == CTL_ON);
        dec.branch_en = (ctrl_word[B_LSB +: 2] == CTL_ON);
        dec.wait_en = (ctrl_word[W_LSB +: 2] == CTL_ON);
        dec.request_byte_count = ctrl_word[15:0];
        dec.next_descriptor_pointer = {branch_word[31:4], 4'h0};
        dec.blk_count = branch_word[3:0];
        dec.blk_ok = (dec.blk_count <= Z_MAX);
    end
endmodule : desc_decode

// ==== rtl/ctx_match.sv ====
module ctx_match
    import iso_rx_pkg::*;
(
    input wire logic [NUM_CTX-1:0] run,
    input wire logic [NUM_CTX-1:0] multi,
    input wire logic [NUM_CTX-1:0][5:0] chan,
    input wire logic [5:0] pkt_channel,
    output logic hit,
    output logic [CTX_W-1:0] idx
);
    logic [NUM_CTX-1:0] multi_first;
    logic [NUM_CTX-1:0] take;

    // Only the lowest-numbered multi-channel context is honoured; others act single.
    for (genvar n = 0; n < NUM_CTX; n++) begin : g_ctx
        if (n == 0) begin : g_first
            assign multi_first[n] = multi[n];
        end else begin : g_rest
            assign multi_first[n] = multi[n] && (multi[n-1:0] == '0);
        end
        assign take[n] = run[n] && (multi_first[n] || chan[n] == pkt_channel);
    end

    always_comb begin
        hit = |take;
        idx = '0;
        for (int n = NUM_CTX - 1; n >= 0; n--) begin
            if (take[n]) begin
                idx = CTX_W'(n);
            end
        end
    end
endmodule : ctx_match

// ==== verification/iso_receive_dma_properties.sv ====
module iso_receive_dma_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic pkt_ready,
    input wire logic iso_receive_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("access unanswered");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error answer");
    quad_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
        else $error("unaligned access");
    status_slot_a: assert property (mem_req && mem_we |-> mem_addr[3:0] == 4'hc)
        else $error("stray write-back");
    quad_order_a: assert property (mem_req && mem_ack && !mem_we && mem_addr[3:0] != 4'hc
        |-> ##1 !mem_req ##1 (mem_req && !mem_we && mem_addr == $past(mem_addr, 2) + 32'h4))
        else $error("fetch out of order");
    req_hold_a: assert property (mem_req && !mem_ack
        |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
        else $error("request changed early");
    irq_pulse_a: assert property (iso_receive_irq |=> !iso_receive_irq)
        else $error("irq too long");
    pkt_pulse_a: assert property (pkt_ready |=> !pkt_ready)
        else $error("pkt_ready too long");

    irq_seen_c: cover property (iso_receive_irq);
    writeback_seen_c: cover property (mem_req && mem_ack && mem_we);
    slverr_seen_c: cover property (pready && pslverr);
endmodule : iso_receive_dma_checker

// ==== verification/host_mem_model.sv ====
module host_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] lat,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] words [0:255];
    logic [31:0] wr_addr, wr_data, head_addr;
    logic [3:0] wait_q;
    int nwr = 0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_q <= 4'h0;
            mem_rdata <= 32'h5a5a_a5a5;
        end else if (mem_ack) begin
            // Inverted data after the acknowledge exposes late sampling.
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_we) begin
                words[mem_addr[9:2]] <= mem_wdata;
                nwr <= nwr + 1;
                wr_addr <= mem_addr;
                wr_data <= mem_wdata;
            end else if (mem_addr[3:0] == 4'h0) begin
                head_addr <= mem_addr;
            end
        end else if (mem_req && wait_q == lat) begin
            mem_ack <= 1'b1;
            mem_rdata <= words[mem_addr[9:2]];
            wait_q <= 4'h0;
        end else if (mem_req) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : host_mem_model

// ==== verification/tb_iso_receive_dma.sv ====
module tb_iso_receive_dma;
    timeunit 1ns;
    timeprecision 1ps;
    import iso_rx_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pkt_valid = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [5:0] pkt_channel = 6'h00;
    logic [3:0] pkt_sync = 4'h0, lat = 4'h0;
    logic [15:0] pkt_length = 16'h0000;
    logic pready, pslverr, mem_req, mem_we, mem_ack, pkt_ready, iso_receive_irq;
    logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
    int errors = 0;
    int tests_run = 0;
    int irqs = 0;

    iso_receive_dma dut (.*);
    host_mem_model mem (.*);

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (iso_receive_irq === 1'b1) irqs++;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(n), 32'h2);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
            input logic exp_err);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(rd & m, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask : rdc

    // A packet is offered only while the engine is quiet, since it takes one at a time.
    task automatic pkt(input logic [5:0] ch, input logic [3:0] sy, input logic [15:0] len);
        int n;
        int idle;
        @(posedge pclk);
        pkt_valid <= 1'b1;
        pkt_channel <= ch;
        pkt_sync <= sy;
        pkt_length <= len;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pkt_ready !== 1'b1 && n < 20);
        pkt_valid <= 1'b0;
        chk(32'(n), 32'h2);
        idle = 0;
        for (n = 0; n < 3000 && idle < 12; n++) begin
            @(posedge pclk);
            idle = (mem_req === 1'b0) ? idle + 1 : 0;
        end
    endtask : pkt

    task automatic ctx_go(input logic [3:0] c, input logic [31:0] ctrl, input logic [31:0] match,
            input logic [31:0] ptr);
        wr({CTX_REGION, c, OFF_CTRL}, 32'h0);
        wr({CTX_REGION, c, OFF_PTR}, ptr);
        wr({CTX_REGION, c, OFF_MATCH}, match);
        wr({CTX_REGION, c, OFF_CTRL}, ctrl | (32'h1 << CTRL_RUN_BIT));
    endtask : ctx_go

    // Branch control is always on here; the stale status word is filled to catch its reuse.
    task automatic put(input logic [31:0] a, input logic [3:0] cmd, input logic s,
            input logic [1:0] i, input logic [1:0] w, input logic [15:0] req, input logic [31:0] nx);
        mem.words[a[9:2]] = {cmd, s, KEY_ZERO, 2'b00, i, CTL_ON, w, req};
        mem.words[a[9:2] + 8'h1] = 32'h0000_0400 + a;
        mem.words[a[9:2] + 8'h2] = nx;
        mem.words[a[9:2] + 8'h3] = 32'hffff_ffff;
    endtask : put

    task automatic wb(input logic [31:0] a, input logic [15:0] resid);
        chk(mem.wr_addr, a);
        chk(mem.wr_data & 32'h8200_ffff, {16'h8000, resid});
    endtask : wb

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({mem_req, pready, pkt_ready, iso_receive_irq}), 32'h0);
        rdc(ADDR_INFO, 32'hffff_ffff, 32'h4, 1'b0);
        rdc(12'h200, 32'hffff_ffff, 32'h0, 1'b1);
        wr({CTX_REGION, 4'h0, OFF_PTR}, 32'h0000_0107);
        rdc({CTX_REGION, 4'h0, OFF_PTR}, 32'hffff_ffff, 32'h0000_0100, 1'b0);
        rdc({CTX_REGION, 4'h0, OFF_CTRL}, 32'hffff_ffff, CTRL_RESET, 1'b0);
        put(32'h100, CMD_LAST, 1'b1, CTL_ON, CTL_OFF, 16'h0040, {28'h0, Z_END});
        ctx_go(4'h0, 32'h0, 32'h0000_0005, 32'h100);
        pkt(6'h05, 4'h0, 16'h0010);
        wb(32'h10c, 16'h0030);
        chk(mem.head_addr, 32'h100);
        chk(32'(irqs), 32'h1);
        rdc({CTX_REGION, 4'h0, OFF_CTRL}, 32'h1 << CTRL_DEAD_BIT, 32'h1 << CTRL_DEAD_BIT, 1'b0);
        lat <= 4'h3;
        put(32'h140, CMD_LAST, 1'b1, CTL_ON, CTL_OFF, 16'h0040, 32'h0);
        ctx_go(4'h1, 32'h1 << CTRL_HDR_BIT, 32'h0000_0007, 32'h140);
        pkt(6'h07, 4'h0, 16'h0010);
        wb(32'h14c, 16'h0030 - HDR_BYTES[15:0]);
        put(32'h180, CMD_LAST, 1'b0, CTL_OFF, CTL_OFF, 16'h0040, 32'h0);
        ctx_go(4'h2, 32'h0, 32'h0000_0009, 32'h180);
        pkt(6'h09, 4'h0, 16'h0010);
        chk(32'(mem.nwr), 32'h2);
        chk(32'(irqs), 32'h2);
        put(32'h1c0, CMD_LAST, 1'b1, CTL_OFF, CTL_OFF, 16'h0008, 32'h0);
        ctx_go(4'h3, 32'h0, 32'h0000_000b, 32'h1c0);
        pkt(6'h0b, 4'h0, 16'h0020);
        wb(32'h1cc, 16'h0000);
        lat <= 4'h0;
        put(32'h200, CMD_MORE, 1'b0, CTL_OFF, CTL_OFF, 16'h0010, 32'h0000_0241);
        put(32'h240, CMD_MORE, 1'b0, CTL_OFF, CTL_OFF, 16'h0020, 32'h0);
        ctx_go(4'h0, 32'h1 << CTRL_STREAM_BIT, 32'h0000_0005, 32'h200);
        pkt(6'h05, 4'h0, 16'h0010);
        wb(32'h20c, 16'h0000);
        pkt(6'h05, 4'h0, 16'h0008);
        wb(32'h24c, 16'h0018);
        chk(mem.head_addr, 32'h240);
        put(32'h280, CMD_LAST, 1'b1, CTL_OFF, CTL_ON, 16'h0040, 32'h0);
        ctx_go(4'h1, 32'h0, 32'h0000_0307, 32'h280);
        pkt(6'h07, 4'h2, 16'h0010);
        chk(mem.wr_addr, 32'h24c);
        pkt(6'h07, 4'h3, 16'h0010);
        wb(32'h28c, 16'h0030);
        put(32'h2c0, 4'h5, 1'b1, CTL_OFF, CTL_OFF, 16'h0040, 32'h0);
        ctx_go(4'h2, 32'h0, 32'h0000_0009, 32'h2c0);
        pkt(6'h09, 4'h0, 16'h0010);
        rdc({CTX_REGION, 4'h2, OFF_CTRL}, 32'h1 << CTRL_ERR_BIT, 32'h1 << CTRL_ERR_BIT, 1'b0);
        put(32'h300, CMD_LAST, 1'b1, CTL_OFF, CTL_OFF, 16'h0040, 32'h0);
        ctx_go(4'h3, 32'h1 << CTRL_MULTI_BIT, 32'h0000_0000, 32'h300);
        pkt(6'h2a, 4'h0, 16'h0004);
        wb(32'h30c, 16'h003c);
        give_verdict();
    end

    initial begin
        #200us;
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule : tb_iso_receive_dma

bind iso_receive_dma iso_receive_dma_checker chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .pkt_ready(pkt_ready), .iso_receive_irq(iso_receive_irq));
